/* hdl/fls_flash_status.sv */
// Status register one, write-enable gating, protection and discovery table of a serial flash.
// Assumes the host drives sck, cs_n and mosi asynchronously to i_clk, in mode 0,
// with sck well below a quarter of the 50 MHz system clock.
`timescale 1ns/1ps

module fls_flash_status (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire fls_pkg::fls_spi_in_t  i_spi,
    input  wire logic                  i_wp_n,
    input  wire fls_pkg::fls_bus_req_t i_bus,
    output logic                       o_miso,
    output logic                       o_miso_oe,
    output logic [7:0]                 o_rdata
);
    import fls_pkg::*;

    fls_state_t s;
    fls_state_t next_s;

    logic       sck_rise;
    logic       sck_fall;
    logic       cs_active;
    logic       frame_end;
    logic [7:0] byte_in;
    logic [7:0] status_now;
    logic [2:0] bp_now;
    logic       whole_bytes;
    logic       locked;
    logic       is_write_cmd;
    logic       wel_cmd;
    logic       wrr_go;
    logic       lock_hit;
    logic       no_wel_hit;
    logic       prog_reject;
    logic       erase_reject;

    // Discovery table; bytes outside the listed range read as fill.
    function automatic logic [7:0] disc_byte(input logic [7:0] a, input logic uniform);
        logic [7:0] d;
        d = DISC_FILL;
        case (a)
            8'h12: d = DISC_ALL_MODES;
            8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h1a, 8'h1b: d = DISC_FILL;
            8'h18, 8'h19, 8'h1c, 8'h1d: d = DISC_FILL;
            8'h1e: d = uniform ? DISC_T1_SIZE_UNI : DISC_T1_SIZE_HYB;
            8'h1f: d = uniform ? DISC_T1_OP_UNI : DISC_T1_OP_HYB;
            8'h20: d = uniform ? DISC_NONE : DISC_T2_SIZE_HYB;
            8'h21: d = DISC_T2_OP;
            8'h22, 8'h24: d = DISC_NONE;
            8'h23, 8'h25: d = DISC_FILL;
            default: d = DISC_FILL;
        endcase
        return d;
    endfunction

    // Sector index is the top address byte; each protect step doubles the top range.
    function automatic logic prot_hit(input logic [7:0] sector, input logic [2:0] bp);
        logic [8:0] span;
        span = 9'h001 << ({1'b0, bp} + 4'h1);
        return (bp != 3'h0) && ({1'b0, ~sector} < span);
    endfunction

    assign sck_rise   = s.sck_s2 & ~s.sck_s3;
    assign sck_fall   = ~s.sck_s2 & s.sck_s3;
    assign cs_active  = ~s.cs_s2;
    assign frame_end  = s.cs_s2 & ~s.cs_s3;
    assign byte_in    = {s.shift[6:0], s.mosi_s2};
    assign bp_now     = s.bp_volatile ? s.vol_bp : s.nv_bp;
    assign status_now = {s.status_write_disable, s.p_err, s.e_err, bp_now, s.write_enable_latch, s.busy};

    // Commands act only on a frame of whole bytes that arrives while idle.
    assign whole_bytes  = (s.bit_cnt == 3'h0) && (s.byte_cnt != 2'h0);
    assign locked       = s.status_write_disable & ~s.wp_s2;
    assign is_write_cmd = (s.opcode == CMD_WRITE_REGISTERS) || (s.opcode == CMD_PROGRAM)
                       || (s.opcode == CMD_ERASE_SMALL) || (s.opcode == CMD_ERASE_LARGE);
    assign wel_cmd      = frame_end && whole_bytes && !s.busy
                       && ((s.opcode == CMD_SET_WRITE_ENABLE)
                        || (s.opcode == CMD_CLEAR_WRITE_ENABLE));
    assign lock_hit     = frame_end && whole_bytes && !s.busy && s.write_enable_latch && locked
                       && (s.opcode == CMD_WRITE_REGISTERS);
    assign wrr_go       = frame_end && whole_bytes && !s.busy && s.write_enable_latch && !locked
                       && (s.opcode == CMD_WRITE_REGISTERS) && (s.byte_cnt >= 2'h2);
    assign no_wel_hit   = frame_end && whole_bytes && !s.busy && !s.write_enable_latch && is_write_cmd;
    assign prog_reject  = frame_end && whole_bytes && !s.busy && s.write_enable_latch
                       && (s.opcode == CMD_PROGRAM) && (s.byte_cnt >= 2'h2)
                       && prot_hit(s.arg0, bp_now);
    assign erase_reject = frame_end && whole_bytes && !s.busy && s.write_enable_latch
                       && ((s.opcode == CMD_ERASE_SMALL) || (s.opcode == CMD_ERASE_LARGE))
                       && (s.byte_cnt >= 2'h2) && prot_hit(s.arg0, bp_now);

    always_comb begin
        logic [7:0] op;
        logic [7:0] a;
        op     = 8'h00;
        a      = 8'h00;
        next_s = s;

        // Two flops on every pin before any logic looks at it.
        next_s.sck_s1  = i_spi.sck;
        next_s.sck_s2  = s.sck_s1;
        next_s.sck_s3  = s.sck_s2;
        next_s.cs_s1   = i_spi.cs_n;
        next_s.cs_s2   = s.cs_s1;
        next_s.cs_s3   = s.cs_s2;
        next_s.mosi_s1 = i_spi.mosi;
        next_s.mosi_s2 = s.mosi_s1;
        next_s.wp_s1   = i_wp_n;
        next_s.wp_s2   = s.wp_s1;

        // Internal operation timer.
        if (s.busy) begin
            if (s.busy_cnt == '0) begin
                next_s.busy = 1'b0;
            end else begin
                next_s.busy_cnt = s.busy_cnt - BUSY_W'(1);
            end
        end

        if (!cs_active) begin
            next_s.bit_cnt = 3'h0;
            next_s.tx      = DISC_FILL;
            if (!frame_end) begin
                next_s.byte_cnt = 2'h0;
            end
            next_s.miso_oe = 1'b0;
        end else if (sck_rise) begin
            next_s.shift   = byte_in;
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
                op = (s.byte_cnt == 2'h0) ? byte_in : s.opcode;
                case (s.byte_cnt)
                    2'h0: next_s.opcode = byte_in;
                    2'h1: next_s.arg0 = byte_in;
                    2'h2: next_s.arg1 = byte_in;
                    default: next_s.arg1 = s.arg1;
                endcase
                if (s.byte_cnt != 2'h3) begin
                    next_s.byte_cnt = s.byte_cnt + 2'h1;
                end
                // Reply bytes load on the edge that ends a byte, shift out on falls.
                if (op == CMD_READ_STATUS) begin
                    next_s.tx = status_now;
                end else if (op == CMD_READ_DISCOVERY && s.byte_cnt != 2'h0) begin
                    a              = (s.byte_cnt == 2'h1) ? byte_in : s.rd_addr;
                    next_s.tx      = disc_byte(a, s.esize_opt);
                    next_s.rd_addr = a + 8'h01;
                end
            end
        end else if (sck_fall) begin
            next_s.miso    = s.tx[7];
            next_s.tx      = {s.tx[6:0], 1'b1};
            next_s.miso_oe = 1'b1;
        end

        // Commands execute on the rising edge of chip select.
        if (frame_end && whole_bytes && !s.busy) begin
            case (s.opcode)
                CMD_SET_WRITE_ENABLE: next_s.write_enable_latch = 1'b1;
                CMD_CLEAR_WRITE_ENABLE: next_s.write_enable_latch = 1'b0;
                CMD_CLEAR_STATUS: begin
                    next_s.p_err = 1'b0;
                    next_s.e_err = 1'b0;
                end
                CMD_WRITE_REGISTERS: begin
                    // The latch is left alone here; only the enable commands touch it.
                    if (wrr_go) begin
                        next_s.status_write_disable = s.arg0[SR_WRITE_DISABLE];
                        if (s.bp_volatile) begin
                            next_s.vol_bp = s.arg0[SR_BP_MSB:SR_BP_LSB];
                        end else begin
                            next_s.nv_bp = s.arg0[SR_BP_MSB:SR_BP_LSB];
                        end
                        if (s.byte_cnt == 2'h3) begin
                            next_s.bp_volatile = s.arg1[CR_BP_VOLATILE];
                        end
                        next_s.busy     = 1'b1;
                        next_s.busy_cnt = BUSY_W'(WRITE_REGS_CYC - 1);
                    end
                end
                CMD_PROGRAM: begin
                    if (s.write_enable_latch && s.byte_cnt >= 2'h2) begin
                        if (prog_reject) begin
                            next_s.p_err = 1'b1;
                        end else begin
                            next_s.busy     = 1'b1;
                            next_s.busy_cnt = BUSY_W'(PROGRAM_CYC - 1);
                        end
                    end
                end
                CMD_ERASE_SMALL, CMD_ERASE_LARGE: begin
                    if (s.write_enable_latch && s.byte_cnt >= 2'h2) begin
                        if (erase_reject) begin
                            next_s.e_err = 1'b1;
                        end else begin
                            next_s.busy     = 1'b1;
                            next_s.busy_cnt = BUSY_W'(ERASE_CYC - 1);
                        end
                    end
                end
                default: next_s.opcode = s.opcode;
            endcase
        end

        // Local register port; read data stands for one cycle only.
        next_s.rdata = 8'h00;
        if (i_bus.rd) begin
            if (i_bus.addr <= ADDR_DISC_LAST) begin
                next_s.rdata = disc_byte(i_bus.addr, s.esize_opt);
            end else if (i_bus.addr == ADDR_STATUS_ONE) begin
                next_s.rdata = status_now;
            end else if (i_bus.addr == ADDR_CONFIG_ONE) begin
                next_s.rdata = {4'h0, s.bp_volatile, 3'h0};
            end else if (i_bus.addr == ADDR_OPTION) begin
                next_s.rdata = {6'h00, s.esize_done, s.esize_opt};
            end
        end
        // The erase-size option takes one write per reset: the first write after reset sticks.
        if (i_bus.wr && i_bus.addr == ADDR_OPTION && !s.esize_done) begin
            next_s.esize_opt  = i_bus.wdata[0];
            next_s.esize_done = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s        <= '0;
            s.sck_s1 <= 1'b0;
            s.cs_s1  <= 1'b1;
            s.cs_s2  <= 1'b1;
            s.cs_s3  <= 1'b1;
            s.wp_s1  <= 1'b1;
            s.wp_s2  <= 1'b1;
            s.tx     <= DISC_FILL;
            s.vol_bp <= RST_VOL_BP;
            s.nv_bp  <= RST_NV_BP;
        end else begin
            s <= next_s;
        end
    end

    assign o_miso    = s.miso;
    assign o_miso_oe = s.miso_oe;
    assign o_rdata   = s.rdata;

    a_lock_freezes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        lock_hit |=> (s.status_write_disable == $past(s.status_write_disable)) && !s.busy
                     && (s.nv_bp == $past(s.nv_bp)) && (s.vol_bp == $past(s.vol_bp)))
        else $error("locked register write changed state");

    a_unlocked_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (frame_end && whole_bytes && !s.busy && s.write_enable_latch && !s.status_write_disable && !s.wp_s2
         && s.opcode == CMD_WRITE_REGISTERS && s.byte_cnt >= 2'h2) |=> s.busy)
        else $error("unlocked register write was not accepted");

    a_err_source: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(s.p_err) |-> $past(prog_reject))
        else $error("program error flag rose without a rejected program");

    a_prot_reject: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        erase_reject |=> s.e_err && !s.busy)
        else $error("erase into protected range was not rejected");

    a_wel_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        no_wel_hit |=> !s.busy && (s.status_write_disable == $past(s.status_write_disable)))
        else $error("write command ran with latch clear");

    // Reset itself clears the latch, so the edge that releases reset is not a command edge.
    a_wel_only_cmds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($changed(s.write_enable_latch) && $past(i_rst_n)) |-> $past(wel_cmd))
        else $error("write enable latch changed outside enable commands");

    a_busy_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wrr_go |=> s.busy [*8] ##1 s.busy)
        else $error("busy did not hold during register write");

    a_busy_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(s.busy) |-> ($past(s.busy_cnt) == '0))
        else $error("busy cleared before the timer ran out");

    a_rom_modes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == 8'h12) |=> (o_rdata == DISC_ALL_MODES))
        else $error("discovery byte 12h wrong");

    a_rom_type1: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == 8'h1e)
        |=> (o_rdata == ($past(s.esize_opt) ? DISC_T1_SIZE_UNI : DISC_T1_SIZE_HYB)))
        else $error("discovery byte 1Eh wrong");

    a_rom_type2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == 8'h21) |=> (o_rdata == DISC_T2_OP))
        else $error("discovery byte 21h wrong");

    a_rom_dual_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == 8'h19) |=> (o_rdata == DISC_FILL))
        else $error("discovery byte 19h wrong");

    a_rom_reserved: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == 8'h1a) |=> (o_rdata == DISC_FILL))
        else $error("discovery byte 1Ah wrong");

    a_rom_type1_op: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == 8'h1f)
        |=> (o_rdata == ($past(s.esize_opt) ? DISC_T1_OP_UNI : DISC_T1_OP_HYB)))
        else $error("discovery byte 1Fh wrong");

    a_rom_t2_size: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == 8'h20)
        |=> (o_rdata == ($past(s.esize_opt) ? DISC_NONE : DISC_T2_SIZE_HYB)))
        else $error("discovery byte 20h wrong");

    a_rom_unsup: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == 8'h24) |=> (o_rdata == DISC_NONE))
        else $error("discovery byte 24h wrong");

    a_wel_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wel_cmd && s.opcode == CMD_SET_WRITE_ENABLE) |=> s.write_enable_latch)
        else $error("set write enable did not set the latch");

    a_wel_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wel_cmd && s.opcode == CMD_CLEAR_WRITE_ENABLE) |=> !s.write_enable_latch)
        else $error("clear write enable did not clear the latch");

    a_erase_runs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (frame_end && whole_bytes && !s.busy && s.write_enable_latch && s.byte_cnt >= 2'h2 && !erase_reject
         && (s.opcode == CMD_ERASE_SMALL || s.opcode == CMD_ERASE_LARGE)) |=> s.busy)
        else $error("enabled erase outside the protected range did not start");

endmodule // fls_flash_status

/* hdl/fls_pkg.sv */
// Shared constants and carrier types for the flash status and discovery block.
// Assumes a 50 MHz system clock and a host that drives the serial pins in mode 0.
package fls_pkg;

    // System clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 20;

    // Internal operation times in nanoseconds and their cycle counts.
    localparam int T_WRITE_REGS_NS = 20000;
    localparam int T_PROGRAM_NS    = 40000;
    localparam int T_ERASE_NS      = 80000;
    localparam int WRITE_REGS_CYC  = (T_WRITE_REGS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYC     = (T_PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYC       = (T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W          = 12;

    // Serial command opcodes.
    localparam logic [7:0] CMD_WRITE_REGISTERS    = 8'h01;
    localparam logic [7:0] CMD_PROGRAM            = 8'h02;
    localparam logic [7:0] CMD_CLEAR_WRITE_ENABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS        = 8'h05;
    localparam logic [7:0] CMD_SET_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] CMD_ERASE_SMALL        = 8'h20;
    localparam logic [7:0] CMD_CLEAR_STATUS       = 8'h30;
    localparam logic [7:0] CMD_READ_DISCOVERY     = 8'h5a;
    localparam logic [7:0] CMD_ERASE_LARGE        = 8'hd8;

    // Local register port addresses; discovery bytes sit at their own offsets.
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h80;
    localparam logic [7:0] ADDR_CONFIG_ONE = 8'h81;
    localparam logic [7:0] ADDR_OPTION     = 8'h82;
    localparam logic [7:0] ADDR_DISC_LAST  = 8'h3f;

    // Status register one bit positions.
    localparam int SR_WRITE_DISABLE = 7;
    localparam int SR_PROGRAM_ERROR = 6;
    localparam int SR_ERASE_ERROR   = 5;
    localparam int SR_BP_MSB        = 4;
    localparam int SR_BP_LSB        = 2;
    localparam int SR_WRITE_ENABLE  = 1;
    localparam int SR_BUSY          = 0;
    // Configuration register one: block-protect bits volatile when set.
    localparam int CR_BP_VOLATILE   = 3;

    // Values after reset.
    localparam logic [2:0] RST_VOL_BP = 3'h7;
    localparam logic [2:0] RST_NV_BP  = 3'h0;

    // Discovery table bytes.
    localparam logic [7:0] DISC_ALL_MODES     = 8'he6;
    localparam logic [7:0] DISC_FILL          = 8'hff;
    localparam logic [7:0] DISC_NONE          = 8'h00;
    localparam logic [7:0] DISC_T1_SIZE_HYB   = 8'h0c;
    localparam logic [7:0] DISC_T1_SIZE_UNI   = 8'h12;
    localparam logic [7:0] DISC_T1_OP_HYB     = 8'h20;
    localparam logic [7:0] DISC_T1_OP_UNI     = 8'hd8;
    localparam logic [7:0] DISC_T2_SIZE_HYB   = 8'h10;
    localparam logic [7:0] DISC_T2_OP         = 8'hd8;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic mosi;
    } fls_spi_in_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fls_bus_req_t;

    typedef struct packed {
        logic              sck_s1, sck_s2, sck_s3;
        logic              cs_s1, cs_s2, cs_s3;
        logic              mosi_s1, mosi_s2;
        logic              wp_s1, wp_s2;
        logic [2:0]        bit_cnt;
        logic [1:0]        byte_cnt;
        logic [7:0]        shift;
        logic [7:0]        opcode;
        logic [7:0]        arg0;
        logic [7:0]        arg1;
        logic [7:0]        tx;
        logic [7:0]        rd_addr;
        logic              status_write_disable;
        logic              p_err;
        logic              e_err;
        logic [2:0]        nv_bp;
        logic [2:0]        vol_bp;
        logic              bp_volatile;
        logic              write_enable_latch;
        logic              busy;
        logic [BUSY_W-1:0] busy_cnt;
        logic              esize_opt;
        logic              esize_done;
        logic              miso;
        logic              miso_oe;
        logic [7:0]        rdata;
    } fls_state_t;

endpackage

/* dv/fls_host_model.sv */
// Host serial controller model that frames whole bytes in mode 0, MSB first.
// Assumes the system clock of the block; each link clock phase spans four system clocks.
`timescale 1ns/1ps
module fls_host_model (
    input  wire logic            i_clk,
    input  wire logic            i_miso,
    output fls_pkg::fls_spi_in_t o_spi
);
    import fls_pkg::*;

    initial begin
        o_spi = 3'b010;
    end

    // The link clock stands low between frames; miso is taken late in the high phase,
    // well clear of the edges where the block moves it.
    task automatic xfer(input logic [23:0] tx, input int nbytes, output logic [7:0] rx);
        logic [23:0] sh;
        sh = tx;
        rx = 8'h00;
        @(posedge i_clk);
        o_spi.cs_n <= 1'b0;
        for (int i = 0; i < nbytes * 8; i++) begin
            o_spi.mosi <= sh[23];
            sh = sh << 1;
            repeat (4) @(posedge i_clk);
            o_spi.sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            rx = {rx[6:0], i_miso};
            o_spi.sck <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_spi.cs_n <= 1'b1;
        o_spi.mosi <= ~o_spi.mosi;
        repeat (6) @(posedge i_clk);
    endtask

    // A write sent through this task is always preceded by its own enable frame.
    task automatic xfer_we(input logic [23:0] tx, input int nbytes);
        logic [7:0] rx;
        xfer({CMD_SET_WRITE_ENABLE, 16'h0000}, 1, rx);
        xfer(tx, nbytes, rx);
    endtask
endmodule // fls_host_model

/* dv/testbench.sv */
// Self-checking bench for the flash status and discovery block.
// Assumes the host model on the serial side and a plain register port on the other.
`timescale 1ns/1ps
module testbench;
    import fls_pkg::*;

    logic         i_clk;
    logic         i_rst_n;
    logic         wp_n;
    logic         miso;
    logic         miso_oe;
    logic         miso_w;
    logic         tog;
    logic [7:0]   rdata;
    logic [7:0]   d;
    fls_spi_in_t  spi;
    fls_bus_req_t bus;
    int           n_errors;
    int           checks_done;
    int           cyc;
    int           t0;

    // Upper byte is the address, lower byte the value for the hybrid layout.
    localparam logic [15:0] ROWS [24] = '{16'h12e6, 16'h13ff, 16'h14ff, 16'h15ff,
        16'h16ff, 16'h17ff, 16'h18ff, 16'h19ff, 16'h1aff, 16'h1bff, 16'h1cff, 16'h1dff,
        16'h1e0c, 16'h1f20, 16'h2010, 16'h21d8, 16'h2200, 16'h23ff, 16'h2400, 16'h25ff,
        16'h00ff, 16'h4000, 16'h8000, 16'h8300};
    localparam logic [15:0] UNI [4] = '{16'h1e12, 16'h1fd8, 16'h2000, 16'h21d8};

    // A released data line toggles so a stale value can never pass as data.
    assign miso_w = miso_oe ? miso : tog;

    fls_flash_status dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_spi(spi), .i_wp_n(wp_n),
        .i_bus(bus), .o_miso(miso), .o_miso_oe(miso_oe), .o_rdata(rdata));
    fls_host_model host (.i_clk(i_clk), .i_miso(miso_w), .o_spi(spi));

    always #10 i_clk = ~i_clk;

    task automatic conclude();
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        tog <= ~tog;
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= v;
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // Polls the busy bit with a bounded count; a hang leaves busy set for later checks.
    task automatic wait_idle();
        d = 8'h01;
        for (int k = 0; k < 3000 && d[0] !== 1'b0; k++) rd(ADDR_STATUS_ONE, d);
    endtask

    initial begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        wp_n = 1'b1;
        bus = '0;
        tog = 1'b0;
        cyc = 0;
        n_errors = 0;
        checks_done = 0;
        repeat (2) @(posedge i_clk);
        #1 chk(rdata, 8'h00);
        chk({6'h00, miso, miso_oe}, 8'h00);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        foreach (ROWS[i]) begin
            rd(ROWS[i][15:8], d);
            chk(d, ROWS[i][7:0]);
        end
        @(posedge i_clk);
        #1 chk(rdata, 8'h00);
        host.xfer({CMD_READ_DISCOVERY, 8'h12, 8'h00}, 3, d);
        chk(d, 8'he6);
        host.xfer({CMD_WRITE_REGISTERS, 8'h9c, 8'h00}, 3, d);
        rchk(ADDR_STATUS_ONE, 8'h00);
        host.xfer({CMD_SET_WRITE_ENABLE, 16'h0000}, 1, d);
        host.xfer({CMD_READ_STATUS, 16'h0000}, 2, d);
        chk(d, 8'h02);
        host.xfer({CMD_CLEAR_WRITE_ENABLE, 16'h0000}, 1, d);
        rchk(ADDR_STATUS_ONE, 8'h00);
        // Error and latch bits written here must be ignored; a clear during busy is refused.
        host.xfer_we({CMD_WRITE_REGISTERS, 8'hfd, 8'h00}, 3);
        t0 = cyc;
        host.xfer({CMD_CLEAR_WRITE_ENABLE, 16'h0000}, 1, d);
        rd(ADDR_STATUS_ONE, d);
        chk(d & 8'h03, 8'h03);
        wait_idle();
        chk({7'h00, (cyc - t0 >= 985) && (cyc - t0 <= 1015)}, 8'h01);
        rchk(ADDR_STATUS_ONE, 8'h9e);
        wp_n <= 1'b0;
        host.xfer_we({CMD_WRITE_REGISTERS, 8'h00, 8'h00}, 3);
        rchk(ADDR_STATUS_ONE, 8'h9e);
        wp_n <= 1'b1;
        host.xfer_we({CMD_WRITE_REGISTERS, 8'h00, 8'h00}, 3);
        wait_idle();
        wp_n <= 1'b0;
        host.xfer_we({CMD_WRITE_REGISTERS, 8'h0c, 8'h00}, 3);
        wait_idle();
        rchk(ADDR_STATUS_ONE, 8'h0e);
        host.xfer_we({CMD_PROGRAM, 8'hff, 8'h00}, 2);
        wait_idle();
        rchk(ADDR_STATUS_ONE, 8'h4e);
        host.xfer_we({CMD_ERASE_SMALL, 8'hf0, 8'h00}, 2);
        wait_idle();
        rchk(ADDR_STATUS_ONE, 8'h6e);
        host.xfer_we({CMD_ERASE_LARGE, 8'h00, 8'h00}, 2);
        rd(ADDR_STATUS_ONE, d);
        chk(d & 8'h01, 8'h01);
        wait_idle();
        rchk(ADDR_STATUS_ONE, 8'h6e);
        host.xfer({CMD_CLEAR_STATUS, 16'h0000}, 1, d);
        host.xfer({CMD_CLEAR_WRITE_ENABLE, 16'h0000}, 1, d);
        host.xfer({CMD_PROGRAM, 8'hff, 8'h00}, 2, d);
        rchk(ADDR_STATUS_ONE, 8'h0c);
        host.xfer_we({CMD_WRITE_REGISTERS, 8'h00, 8'h08}, 3);
        wait_idle();
        rchk(ADDR_CONFIG_ONE, 8'h08);
        wr(ADDR_OPTION, 8'h01);
        wr(ADDR_OPTION, 8'h00);
        rchk(ADDR_OPTION, 8'h03);
        foreach (UNI[i]) begin
            rd(UNI[i][15:8], d);
            chk(d, UNI[i][7:0]);
        end
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rchk(ADDR_STATUS_ONE, 8'h00);
        conclude();
    end
endmodule // testbench
